// [hw/hbridge_supervisor_pkg.sv]
// shared constants and types for the h-bridge fault and sleep supervisor
package hbridge_supervisor_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 50; // 20 MHz system clock
  localparam int OVERCURRENT_DEGLITCH_TIME_NS = 2300; // 2.3 us
  localparam int OVERCURRENT_RETRY_TIME_US = 1400; // 1.4 ms
  localparam int SLEEP_ENTRY_DELAY_NS = 1000; // plain default
  localparam int WAKE_DELAY_NS = 1000; // plain default
  localparam int DEAD_TIME_NS = 100; // plain default

  // least times round up, the retry period rounds down
  localparam int OVERCURRENT_DEGLITCH_CYCLES =
    (OVERCURRENT_DEGLITCH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int OVERCURRENT_RETRY_CYCLES =
    (OVERCURRENT_RETRY_TIME_US * 1000) / CLOCK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYCLES =
    (SLEEP_ENTRY_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WAKE_CYCLES =
    (WAKE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DEAD_CYCLES =
    (DEAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // one half-bridge leg: its high-side and low-side fet
  typedef struct packed {
    logic high_side;
    logic low_side;
  } leg_type;

  localparam leg_type LEG_OFF = '{high_side: 1'b0, low_side: 1'b0};

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic sleep_n;
    logic undervoltage;
    logic over_temp;
    leg_type [1:0][1:0] drive; // [bridge][leg]
    leg_type [1:0][1:0] limit; // [bridge][leg]
  } pin_type;

  localparam pin_type PIN_RESET = '0;

  typedef enum logic {
    OCP_RUN,
    OCP_TRIP
  } ocp_state_type;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_ENTERING,
    MODE_ASLEEP,
    MODE_WAKING
  } power_mode_type;

endpackage

// [hw/bridge_guard.sv]
// one h-bridge: overcurrent deglitch, retry and leg dead time
`timescale 1ns/10ps
module bridge_guard
  import hbridge_supervisor_pkg::*;
#(
  parameter int DEGLITCH = OVERCURRENT_DEGLITCH_CYCLES,
  parameter int RETRY = OVERCURRENT_RETRY_CYCLES,
  parameter int DEAD = DEAD_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in, // internal reset: pin, lockout or sleep
  input wire logic enable_in, // device allows driving
  input wire leg_type [1:0] request_in, // requested fets per leg
  input wire leg_type [1:0] limit_in, // current-limit per fet
  output leg_type [1:0] gate_out, // fet gate commands
  output logic fault_out // overcurrent shutdown active
);

  // ------------------------------------------------------------
  // parameter check and widths
  // ------------------------------------------------------------
  if (DEGLITCH < 1 || RETRY < 2 || DEAD < 1) begin : bad_params
    $error("bridge_guard: counts too small");
  end

  localparam int DEG_W = $clog2(DEGLITCH + 1);
  localparam int RET_W = $clog2(RETRY + 1);
  localparam int DEAD_W = $clog2(DEAD + 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    ocp_state_type mode; // running or tripped
    logic [DEG_W-1:0] glitch; // cycles the limit has held
    logic [RET_W-1:0] retry; // cycles spent tripped
    logic fault; // shutdown flag
    leg_type [1:0] gate; // gate commands
    logic [1:0][DEAD_W-1:0] dead; // dead time left per leg
  } guard_type;

  localparam guard_type GUARD_RESET = '0;

  guard_type state;
  guard_type next_state;
  logic limit_any;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    leg_type target;
    target = LEG_OFF;
    next_state = state;
    // high and low side limits watched alike, no sense path [R5] [R6]
    limit_any = |limit_in;
    unique case (state.mode)
      OCP_RUN: begin
        if (!limit_any) begin
          next_state.glitch = '0; // short pulses are forgotten
        end else if (state.glitch == DEG_W'(DEGLITCH)) begin
          // limit outlasted the deglitch window [R1]
          next_state.mode = OCP_TRIP;
          next_state.fault = 1'b1;
          next_state.retry = '0;
          next_state.glitch = '0;
        end else begin
          next_state.glitch = state.glitch + 1'b1;
        end
      end
      OCP_TRIP: begin
        if (state.retry == RET_W'(RETRY - 1)) begin
          // retry: drive again and release the fault [R2] [R3]
          next_state.mode = OCP_RUN;
          next_state.fault = 1'b0;
        end else begin
          next_state.retry = state.retry + 1'b1;
        end
      end
    endcase
    // per-leg gating with dead time
    for (int leg = 0; leg < 2; leg++) begin
      target = request_in[leg];
      if (target.high_side && target.low_side) begin
        target = LEG_OFF; // both sides asked: treat as off
      end
      if (!enable_in || next_state.mode == OCP_TRIP) begin
        target = LEG_OFF; // disabled or tripped: all fets off [R1]
      end
      if (state.gate[leg] != LEG_OFF && target != state.gate[leg]) begin
        // any switch-off starts the dead time [R15]
        next_state.gate[leg] = LEG_OFF;
        next_state.dead[leg] = DEAD_W'(DEAD);
      end else if (state.dead[leg] != '0) begin
        // hold both off until the dead time ends [R15]
        next_state.gate[leg] = LEG_OFF;
        next_state.dead[leg] = state.dead[leg] - 1'b1;
      end else begin
        next_state.gate[leg] = target;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= GUARD_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign gate_out = state.gate;
  assign fault_out = state.fault;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking guard_clk @(posedge clock_in); endclocking
  default disable iff (reset_in);

  trip_cause_a: assert property ( // [R1]
    $rose(fault_out) |-> $past(limit_any) && $past(state.glitch) ==
      DEG_W'(DEGLITCH))
    else $error("overcurrent trip without a held limit");

  trip_gates_a: assert property ( // [R1]
    fault_out |-> gate_out == '0)
    else $error("fet on during overcurrent shutdown");

  no_quick_trip_a: assert property ( // [R1]
    (state.mode == OCP_RUN && !limit_any) |=> !fault_out)
    else $error("trip without a limit indication");

  retry_length_a: assert property ( // [R2]
    $fell(fault_out) |-> $past(state.retry) == RET_W'(RETRY - 1))
    else $error("retry period wrong length");

  for (genvar l = 0; l < 2; l++) begin : leg_checks
    high_dead_a: assert property ( // [R15]
      $rose(gate_out[l].high_side) |->
        !$past(gate_out[l].low_side, DEAD + 1) &&
        !$past(gate_out[l].low_side))
      else $error("high side on inside dead time");
    low_dead_a: assert property ( // [R15]
      $rose(gate_out[l].low_side) |->
        !$past(gate_out[l].high_side, DEAD + 1) &&
        !$past(gate_out[l].high_side))
      else $error("low side on inside dead time");
  end

endmodule

// [hw/hbridge_fault_sleep_supervisor.sv]
// supervisor for two h-bridges: faults, lockout, sleep and fault pin
`timescale 1ns/10ps
// Contract
// R1: held current limit trips bridge, fault low
// R2: after retry period re-enable, release fault
// R3: cleared overcurrent at retry end resumes normally
// R4: overcurrent stops only its own bridge
// R5: high and low side fets watched separately
// R6: overcurrent ignores the chopping sense path
// R7: over-temperature disables all fets, fault low
// R8: thermal recovery resumes, then releases fault
// R9: undervoltage disables everything and resets logic
// R10: leave lockout only once supply recovered
// R11: undervoltage never drives fault pin low
// R12: sleep pin low holds all outputs off
// R13: asleep only after the sleep-entry delay
// R14: wake automatically, outputs wait wake delay
// R15: dead time between opposite fets of leg
// R16: asleep: logic held reset, drive ignored
// R17: intervals are cycle counters, counts parameters
// R18: fault pin is or of bridge, thermal faults
module hbridge_fault_sleep_supervisor
  import hbridge_supervisor_pkg::*;
#(
  parameter int DEGLITCH = OVERCURRENT_DEGLITCH_CYCLES,
  parameter int RETRY = OVERCURRENT_RETRY_CYCLES,
  parameter int SLEEP_ENTRY = SLEEP_ENTRY_CYCLES,
  parameter int WAKE = WAKE_CYCLES,
  parameter int DEAD = DEAD_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic sleep_in_n, // low requests sleep
  input wire logic undervoltage_in, // supply below lockout level
  input wire logic over_temp_in, // die over temperature
  input wire leg_type [1:0][1:0] drive_in, // [bridge][leg] requests
  input wire leg_type [1:0][1:0] limit_in, // [bridge][leg] limits
  output leg_type [1:0][1:0] gate_out, // [bridge][leg] gates
  output logic fault_out_n, // low while any fault is reported
  output logic asleep_out // device counts as asleep
);

  // ------------------------------------------------------------
  // parameter check and widths
  // ------------------------------------------------------------
  if (SLEEP_ENTRY < 1 || WAKE < 1) begin : bad_params
    $error("supervisor: sleep or wake count too small");
  end

  localparam int DELAY_MAX = (SLEEP_ENTRY > WAKE) ? SLEEP_ENTRY : WAKE;
  localparam int DELAY_W = $clog2(DELAY_MAX + 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pin_type pin_meta; // first synchroniser stage
    pin_type pin_sync; // second synchroniser stage
    power_mode_type mode; // sleep sequencing
    logic [DELAY_W-1:0] delay; // entry or wake cycles elapsed
    logic tsd_active; // thermal shutdown holding fets off
    logic thermal_report; // thermal fault shown on the pin
    logic fault_n; // fault pin level
    logic asleep; // asleep flag
  } super_type;

  localparam super_type SUPER_RESET = '{
    pin_meta: PIN_RESET,
    pin_sync: PIN_RESET,
    mode: MODE_ACTIVE,
    delay: '0,
    tsd_active: 1'b0,
    thermal_report: 1'b0,
    fault_n: 1'b1,
    asleep: 1'b0
  };

  super_type state;
  super_type next_state;
  pin_type pins; // raw pins gathered
  logic [1:0] ocp_fault; // per-bridge shutdown flags
  logic bridge_reset; // internal reset for the bridges
  logic bridge_enable; // bridges may follow drive

  // ------------------------------------------------------------
  // internal reset and enable
  // ------------------------------------------------------------
  always_comb begin
    pins.sleep_n = sleep_in_n;
    pins.undervoltage = undervoltage_in;
    pins.over_temp = over_temp_in;
    pins.drive = drive_in;
    pins.limit = limit_in;
    // lockout and sleep both clear all bridge state [R9] [R16]
    bridge_reset = reset_in || state.pin_sync.undervoltage ||
      state.mode == MODE_ASLEEP;
    // drive only when awake, out of wake delay, not hot [R12] [R14] [R7]
    bridge_enable = state.mode == MODE_ACTIVE && !state.tsd_active;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.pin_meta = pins;
    next_state.pin_sync = state.pin_meta;
    if (state.pin_sync.undervoltage) begin
      // lockout: all but the synchroniser back to reset, pin left high [R9] [R11]
      next_state.mode = SUPER_RESET.mode;
      next_state.delay = SUPER_RESET.delay;
      next_state.tsd_active = SUPER_RESET.tsd_active;
      next_state.thermal_report = SUPER_RESET.thermal_report;
      next_state.fault_n = SUPER_RESET.fault_n;
      next_state.asleep = SUPER_RESET.asleep;
      // leaving happens once the indication drops [R10]
    end else begin
      unique case (state.mode)
        MODE_ACTIVE: begin
          if (!state.pin_sync.sleep_n) begin
            next_state.mode = MODE_ENTERING; // [R12]
            next_state.delay = '0;
          end
        end
        MODE_ENTERING: begin
          if (state.pin_sync.sleep_n) begin
            next_state.mode = MODE_WAKING; // aborted entry
            next_state.delay = '0;
          end else if (state.delay == DELAY_W'(SLEEP_ENTRY - 1)) begin
            next_state.mode = MODE_ASLEEP; // entry delay done [R13] [R17]
          end else begin
            next_state.delay = state.delay + 1'b1;
          end
        end
        MODE_ASLEEP: begin
          if (state.pin_sync.sleep_n) begin
            next_state.mode = MODE_WAKING; // automatic wake [R14]
            next_state.delay = '0;
          end
        end
        MODE_WAKING: begin
          if (!state.pin_sync.sleep_n) begin
            next_state.mode = MODE_ENTERING;
            next_state.delay = '0;
          end else if (state.delay == DELAY_W'(WAKE - 1)) begin
            next_state.mode = MODE_ACTIVE; // wake delay done [R14] [R17]
          end else begin
            next_state.delay = state.delay + 1'b1;
          end
        end
      endcase
      if (state.mode == MODE_ASLEEP) begin
        // asleep: thermal state held cleared [R16]
        next_state.tsd_active = 1'b0;
        next_state.thermal_report = 1'b0;
      end else begin
        // comparator already carries the hysteresis [R7] [R8]
        next_state.tsd_active = state.pin_sync.over_temp;
        // report clears one cycle after drive resumes [R8]
        next_state.thermal_report = state.tsd_active;
      end
      // open fault pin is the or of all reported faults [R18]
      next_state.fault_n = !(|ocp_fault || state.thermal_report);
      next_state.asleep = next_state.mode == MODE_ASLEEP; // [R13]
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= SUPER_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign fault_out_n = state.fault_n;
  assign asleep_out = state.asleep;

  // ------------------------------------------------------------
  // bridges
  // ------------------------------------------------------------
  // each bridge trips and retries on its own limits only [R4]
  for (genvar b = 0; b < 2; b++) begin : bridges
    bridge_guard #(
      .DEGLITCH(DEGLITCH),
      .RETRY(RETRY),
      .DEAD(DEAD)
    ) guard (
      .clock_in(clock_in),
      .reset_in(bridge_reset),
      .enable_in(bridge_enable),
      .request_in(state.pin_sync.drive[b]),
      .limit_in(state.pin_sync.limit[b]),
      .gate_out(gate_out[b]),
      .fault_out(ocp_fault[b])
    );
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking super_clk @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence wake_end_s;
    state.mode == MODE_WAKING && !state.pin_sync.undervoltage
      ##1 state.mode == MODE_ACTIVE;
  endsequence

  sequence hot_s;
    (state.pin_sync.over_temp && !state.pin_sync.undervoltage &&
      state.mode != MODE_ASLEEP)[*3];
  endsequence

  uv_quiet_a: assert property ( // [R11]
    state.pin_sync.undervoltage |=> fault_out_n)
    else $error("fault pin low during undervoltage");

  uv_off_a: assert property ( // [R9]
    state.pin_sync.undervoltage |=> gate_out == '0 && !asleep_out)
    else $error("drive during undervoltage lockout");

  sleep_off_a: assert property ( // [R12]
    state.mode != MODE_ACTIVE |=> gate_out == '0)
    else $error("fet on while not active");

  sleep_entry_a: assert property ( // [R13]
    $rose(asleep_out) |-> $past(state.mode == MODE_ENTERING, SLEEP_ENTRY))
    else $error("asleep before the entry delay");

  wake_delay_a: assert property ( // [R14]
    wake_end_s |-> $past(state.mode == MODE_WAKING, WAKE) &&
      gate_out == '0)
    else $error("outputs woke before the wake delay");

  thermal_trip_a: assert property ( // [R7]
    hot_s |=> !fault_out_n && !bridge_enable)
    else $error("over temperature not reported");

  thermal_order_a: assert property ( // [R8]
    $fell(state.thermal_report) && !$past(state.pin_sync.undervoltage ||
      state.mode == MODE_ASLEEP) |-> $past(!state.tsd_active))
    else $error("thermal fault released before resume");

  fault_merge_a: assert property ( // [R18]
    !fault_out_n |-> $past(|ocp_fault || state.thermal_report))
    else $error("fault pin low without a fault");

endmodule

// [tb/host_model.sv]
// host controller model: drives the sleep pin and watches the fault pin
`timescale 1ns/10ps
module host_model #(
  parameter int ENTRY = 4
) (
  input wire logic clock_in,
  input wire logic want_sleep_in, // bench asks for sleep
  input wire logic fault_pin_n_in, // fault pin of the device
  output logic sleep_pin_n_out, // sleep request pin, low = sleep
  output logic assumed_asleep_out, // host believes device is asleep
  output logic [7:0] fault_count_out // falling edges seen on fault pin
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic request = 1'b0; // registered sleep request
  logic fault_last = 1'b1; // fault pin one edge back
  logic [7:0] count = '0; // edges since the sleep pin fell
  logic [7:0] faults = '0; // fault reports counted

  // ------------------------------------------------------------
  // behaviour
  // ------------------------------------------------------------
  // pin changes on the falling edge only, one cycle after the ask
  always @(negedge clock_in) begin
    request <= want_sleep_in;
  end
  assign sleep_pin_n_out = !request;

  // sleep is assumed only once the entry delay has surely run
  always @(posedge clock_in) begin
    if (sleep_pin_n_out) begin
      count <= '0;
    end else if (count < 8'hFF) begin
      count <= count + 8'h01;
    end
    fault_last <= fault_pin_n_in;
    if (fault_last && !fault_pin_n_in) begin
      faults <= faults + 8'h01;
    end
  end
  assign assumed_asleep_out = (count > 8'(ENTRY + 4));
  assign fault_count_out = faults;
endmodule

// [tb/tb_top.sv]
// self-checking bench for the h-bridge fault and sleep supervisor
`timescale 1ns/10ps
module tb_top;
  import hbridge_supervisor_pkg::*;
  // shortened counts so the run stays small
  localparam int DEG = 3;
  localparam int RET = 20;
  localparam int SLP = 4;
  localparam int WK = 4;
  localparam int DT = 2;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic undervoltage_in = 1'b0;
  logic over_temp_in = 1'b0;
  logic want_sleep = 1'b0;
  leg_type [1:0][1:0] drive_in = '0;
  leg_type [1:0][1:0] limit_in = '0;
  leg_type [1:0][1:0] gate_out;
  logic fault_out_n;
  logic asleep_out;
  logic sleep_in_n;
  logic assumed;
  logic [7:0] faults;
  logic [7:0] want_gate = 8'h96; // forward on bridge 0, reverse on 1
  int miscompares = 0;
  int checked = 0;
  int n;

  always #25 clock_in = ~clock_in;

  hbridge_fault_sleep_supervisor #(.DEGLITCH(DEG), .RETRY(RET),
    .SLEEP_ENTRY(SLP), .WAKE(WK), .DEAD(DT)) u_dut (
    .clock_in(clock_in), .reset_in(reset_in), .sleep_in_n(sleep_in_n),
    .undervoltage_in(undervoltage_in), .over_temp_in(over_temp_in),
    .drive_in(drive_in), .limit_in(limit_in), .gate_out(gate_out),
    .fault_out_n(fault_out_n), .asleep_out(asleep_out));

  host_model #(.ENTRY(SLP)) u_host (
    .clock_in(clock_in), .want_sleep_in(want_sleep),
    .fault_pin_n_in(fault_out_n), .sleep_pin_n_out(sleep_in_n),
    .assumed_asleep_out(assumed), .fault_count_out(faults));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic cond(input int which);
    case (which)
      0: cond = (fault_out_n === 1'b0);
      1: cond = (fault_out_n === 1'b1);
      2: cond = (asleep_out === 1'b1);
      3: cond = ((|gate_out) === 1'b1);
      4: cond = (assumed === 1'b1);
      5: cond = (gate_out[0][0] === 2'b00);
      6: cond = (gate_out === want_gate);
      default: cond = (gate_out === 8'h00);
    endcase
  endfunction

  // bounded wait, n counts falling edges until the condition holds
  task automatic wait_cond(input int which, output int cnt);
    cnt = 0;
    while (!cond(which)) begin
      @(negedge clock_in);
      cnt++;
      if (cnt > 200) begin
        miscompares++;
        $display("mismatch wait %0d expected 1 seen 0", which);
        final_report();
      end
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_dead;
    drive_in = 8'h96;
    wait_cond(6, n);
    drive_in = 8'h95; // bridge 0 leg 0 swaps to its low side
    want_gate = 8'h95;
    wait_cond(5, n);
    wait_cond(6, n);
    check("dead_cycles", 16'(n), 16'(DT + 1));
    drive_in = 8'h96;
    want_gate = 8'h96;
    wait_cond(6, n);
    $display("test dead_time done");
  endtask

  task automatic t_ocp;
    logic [7:0] f0;
    f0 = faults;
    limit_in[0][0].high_side = 1'b1; // glitch just at the deglitch count
    repeat (DEG) @(negedge clock_in);
    limit_in = '0;
    repeat (10) @(negedge clock_in);
    check("glitch_faults", 16'(faults), 16'(f0));
    limit_in[0][1].low_side = 1'b1; // held low-side limit
    wait_cond(0, n);
    check("trip_time", 16'(n > DEG && n <= DEG + 6), 16'h1);
    check("trip_gates", 16'(gate_out), 16'h90);
    wait_cond(1, n);
    check("retry_len", 16'(n), 16'(RET));
    f0 = faults;
    wait_cond(0, n);
    @(negedge clock_in); // host counts the fall one edge later
    check("retrip", 16'(faults), 16'(f0 + 8'h01));
    limit_in = '0;
    wait_cond(1, n);
    repeat (RET + DEG + 8) @(negedge clock_in);
    check("resume_fault", 16'(fault_out_n), 16'h1);
    check("resume_gates", 16'(gate_out), 16'h96);
    limit_in[1][1].high_side = 1'b1; // high side of the other bridge
    wait_cond(0, n);
    check("b1_gates", 16'(gate_out), 16'h06);
    limit_in = '0;
    wait_cond(1, n);
    wait_cond(6, n);
    $display("test overcurrent done");
  endtask

  task automatic t_thermal;
    over_temp_in = 1'b1;
    wait_cond(0, n);
    check("tsd_gates", 16'(gate_out), 16'h00);
    over_temp_in = 1'b0;
    wait_cond(1, n);
    check("tsd_resume", 16'(gate_out), 16'h96);
    $display("test thermal done");
  endtask

  task automatic t_uv;
    limit_in[0][0].high_side = 1'b1;
    wait_cond(0, n);
    undervoltage_in = 1'b1;
    limit_in = '0;
    wait_cond(1, n);
    check("uv_release", 16'(n <= 4), 16'h1);
    repeat (10) begin
      @(negedge clock_in);
      check("uv_fault", 16'(fault_out_n), 16'h1);
      check("uv_gates", 16'(gate_out), 16'h00);
    end
    undervoltage_in = 1'b0;
    wait_cond(6, n);
    check("uv_recover", 16'(n <= 8), 16'h1);
    check("uv_reset", 16'(fault_out_n), 16'h1);
    $display("test undervoltage done");
  endtask

  task automatic t_sleep;
    int n1; // cycles from the ask until the gates went off
    want_sleep <= 1'b1;
    wait_cond(7, n);
    check("sleep_off", 16'(n <= 6), 16'h1);
    n1 = n;
    wait_cond(2, n);
    n1 = n1 + n; // entry measured from the ask, not from gates off
    check("entry_len", 16'(n1 >= SLP && n1 <= SLP + 6), 16'h1);
    wait_cond(4, n);
    check("host_assume", 16'(asleep_out), 16'h1);
    drive_in = 8'h69;
    repeat (6) @(negedge clock_in);
    check("asleep_gates", 16'(gate_out), 16'h00);
    want_sleep <= 1'b0;
    wait_cond(3, n);
    check("wake_len", 16'(n > WK && n <= WK + 8), 16'h1);
    check("awake", 16'(asleep_out), 16'h0);
    want_gate = 8'h69;
    wait_cond(6, n);
    check("wake_drive", 16'(n <= DT + 3), 16'h1);
    $display("test sleep done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clock_in);
    reset_in = 1'b0;
    check("reset_gates", 16'(gate_out), 16'h00);
    check("reset_fault", 16'(fault_out_n), 16'h1);
    check("reset_sleep", 16'(asleep_out), 16'h0);
    t_dead();
    t_ocp();
    t_thermal();
    t_uv();
    t_sleep();
    final_report();
  end
endmodule
